// >>> hdl/rtat_pkg.sv
// constants of the remote target address table
package rtat_pkg;
	// -------------------------------------------------------------
	// register map
	// -------------------------------------------------------------
	localparam logic [7:0] RTAT_OFS_TARGET_2 = 8'h0A;   // index 2, one below index 3
	localparam logic [7:0] RTAT_OFS_TARGET_3 = 8'h0B;
	localparam logic [7:0] RTAT_OFS_TARGET_4 = 8'h0C;
	localparam logic [7:0] RTAT_OFS_TARGET_5 = 8'h0D;
	localparam logic [7:0] RTAT_OFS_TARGET_6 = 8'h0E;
	localparam int         RTAT_FIRST_INDEX  = 2;
	localparam int         RTAT_NUM_TARGETS  = 5;

	// -------------------------------------------------------------
	// field layout and reset values
	// -------------------------------------------------------------
	localparam int         RTAT_ADDR_MSB     = 7;
	localparam int         RTAT_ADDR_LSB     = 1;
	localparam int         RTAT_ADDR_W       = 7;
	localparam logic [6:0] RTAT_ADDR_RESET   = 7'h00;
	localparam logic [6:0] RTAT_ADDR_OFF     = 7'h00;  // zero blocks a target
	localparam logic [7:0] RTAT_READ_NONE    = 8'h00;

	// -------------------------------------------------------------
	// transaction sequencer states
	// -------------------------------------------------------------
	typedef enum logic [0:0] {
		RTAT_IDLE    = 1'b0,
		RTAT_FORWARD = 1'b1
	} rtat_state_type;
endpackage : rtat_pkg

// >>> hdl/rtat_slot.sv
// one remote target entry: stored address and alias compare
`timescale 1ns/1ns
`default_nettype none
module rtat_slot
	import rtat_pkg::*;
(
	input  wire logic                          clock,
	input  wire logic                          nrst,
	input  wire logic                          wr_en,
	input  wire logic [7:0]                    wr_data,
	input  wire logic [rtat_pkg::RTAT_ADDR_W-1:0] alias_addr,
	input  wire logic [rtat_pkg::RTAT_ADDR_W-1:0] txn_addr,
	output logic      [rtat_pkg::RTAT_ADDR_W-1:0] target_addr,
	output logic                               alias_hit,
	output logic                               target_open
);
	logic [RTAT_ADDR_W-1:0] target_q;
	logic [RTAT_ADDR_W-1:0] target_d;

	// -------------------------------------------------------------
	// storage
	// -------------------------------------------------------------
	// bit 0 of the write is dropped
	always_comb begin
		target_d = target_q;
		if (wr_en) begin
			target_d = wr_data[RTAT_ADDR_MSB:RTAT_ADDR_LSB];
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			target_q <= RTAT_ADDR_RESET;
		end else begin
			target_q <= target_d;
		end
	end

	// -------------------------------------------------------------
	// compare
	// -------------------------------------------------------------
	// a zero alias never matches a real address
	assign alias_hit   = (alias_addr != RTAT_ADDR_OFF) && (alias_addr == txn_addr);
	assign target_open = (target_q != RTAT_ADDR_OFF);
	assign target_addr = target_q;
endmodule : rtat_slot
`default_nettype wire

// >>> hdl/rtat_table.sv
// remote target address table with alias remap and forwarding
//
// Notes on behaviour
// - each target register keeps a 7-bit address in bits 7:1, readable and writable, zero after reset.
// - a local transaction hitting the alias of an index is forwarded with that index's stored address.
// - while a target register is zero its index is blocked: no remap and no forwarding.
// - indices 2 to 6 each have their own register at consecutive offsets 0x0A to 0x0E.
// - a local address equal to an alias value is accepted and remapped to the target of the lowest index holding that alias.
`timescale 1ns/1ns
`default_nettype none
module rtat_table
	import rtat_pkg::*;
#(
	parameter int NUM_TARGETS = rtat_pkg::RTAT_NUM_TARGETS,
	parameter int FIRST_INDEX = rtat_pkg::RTAT_FIRST_INDEX
)(
	input  wire logic                                      clock,
	input  wire logic                                      nrst,
	// register port from the control bus slave
	input  wire logic [7:0]                                reg_addr,
	input  wire logic                                      reg_wr_en,
	input  wire logic                                      reg_rd_en,
	input  wire logic [7:0]                                reg_wdata,
	output logic      [7:0]                                reg_rdata,
	output logic                                           reg_ack,
	// alias values held outside this block, index 2 in the low bits
	input  wire logic [NUM_TARGETS*rtat_pkg::RTAT_ADDR_W-1:0] alias_addr,
	// local transaction address phase
	input  wire logic                                      txn_valid,
	input  wire logic [rtat_pkg::RTAT_ADDR_W-1:0]          txn_addr,
	output logic                                           txn_ready,
	output logic                                           txn_miss,
	output logic                                           txn_blocked,
	// forward request toward the control channel
	output logic                                           fwd_valid,
	output logic      [rtat_pkg::RTAT_ADDR_W-1:0]          fwd_addr,
	output logic      [2:0]                                fwd_index,
	input  wire logic                                      fwd_ready
);
	// -------------------------------------------------------------
	// elaboration checks
	// -------------------------------------------------------------
	if (NUM_TARGETS < 1 || FIRST_INDEX < 0 || FIRST_INDEX + NUM_TARGETS > 8) begin : g_bad_param
		$error("rtat_table: index range does not fit a 3-bit index");
	end

	// -------------------------------------------------------------
	// decode helpers
	// -------------------------------------------------------------
	// maps a byte offset to a slot number, or NUM_TARGETS when unmapped
	function automatic int slot_of(input logic [7:0] ofs);
		int s;
		s = NUM_TARGETS;
		for (int i = 0; i < NUM_TARGETS; i++) begin
			if (ofs == RTAT_OFS_TARGET_2 + 8'(i)) begin
				s = i;
			end
		end
		return s;
	endfunction : slot_of

	// -------------------------------------------------------------
	// slots
	// -------------------------------------------------------------
	logic [RTAT_ADDR_W-1:0] slot_target [NUM_TARGETS];
	logic [NUM_TARGETS-1:0] slot_hit;
	logic [NUM_TARGETS-1:0] slot_open;
	logic [NUM_TARGETS-1:0] slot_wr;

	for (genvar g = 0; g < NUM_TARGETS; g++) begin : g_slot
		// one register per index at consecutive offsets
		assign slot_wr[g] = reg_wr_en && (slot_of(reg_addr) == g);

		rtat_slot u_slot (
			.clock       (clock),
			.nrst        (nrst),
			.wr_en       (slot_wr[g]),
			.wr_data     (reg_wdata),
			.alias_addr  (alias_addr[g*RTAT_ADDR_W +: RTAT_ADDR_W]),
			.txn_addr    (txn_addr),
			.target_addr (slot_target[g]),
			.alias_hit   (slot_hit[g]),
			.target_open (slot_open[g])
		);
	end

	// -------------------------------------------------------------
	// register read
	// -------------------------------------------------------------
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic       ack_q;
	logic       ack_d;

	// unmapped offsets read zero, bit 0 always zero
	always_comb begin
		int s;
		s       = slot_of(reg_addr);
		rdata_d = rdata_q;
		ack_d   = reg_rd_en || reg_wr_en;
		if (reg_rd_en) begin
			rdata_d = RTAT_READ_NONE;
			for (int i = 0; i < NUM_TARGETS; i++) begin
				if (s == i) begin
					rdata_d = {slot_target[i], 1'b0};
				end
			end
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rdata_q <= RTAT_READ_NONE;
			ack_q   <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			ack_q   <= ack_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign reg_ack   = ack_q;

	// -------------------------------------------------------------
	// alias match, lowest index wins
	// -------------------------------------------------------------
	logic                   match_any;
	logic                   match_open;
	logic [RTAT_ADDR_W-1:0] match_target;
	logic [2:0]             match_index;

	always_comb begin
		match_any    = 1'b0;
		match_open   = 1'b0;
		match_target = RTAT_ADDR_OFF;
		match_index  = 3'h0;
		for (int i = NUM_TARGETS - 1; i >= 0; i--) begin
			if (slot_hit[i]) begin
				match_any    = 1'b1;
				match_open   = slot_open[i];
				match_target = slot_target[i];
				match_index  = 3'(FIRST_INDEX + i);
			end
		end
	end

	// -------------------------------------------------------------
	// transaction sequencer
	// -------------------------------------------------------------
	rtat_state_type         state_q;
	rtat_state_type         state_d;
	logic [RTAT_ADDR_W-1:0] fwd_addr_q;
	logic [RTAT_ADDR_W-1:0] fwd_addr_d;
	logic [2:0]             fwd_index_q;
	logic [2:0]             fwd_index_d;
	logic                   miss_q;
	logic                   miss_d;
	logic                   blocked_q;
	logic                   blocked_d;

	// takes one address, then holds the forward request until accepted
	always_comb begin
		state_d     = state_q;
		fwd_addr_d  = fwd_addr_q;
		fwd_index_d = fwd_index_q;
		miss_d      = 1'b0;
		blocked_d   = 1'b0;
		unique case (state_q)
			RTAT_IDLE: begin
				if (txn_valid) begin
					if (match_any && match_open) begin
						fwd_addr_d  = match_target;
						fwd_index_d = match_index;
						state_d     = RTAT_FORWARD;
					end else if (match_any) begin
						blocked_d   = 1'b1;
					end else begin
						miss_d      = 1'b1;
					end
				end
			end
			RTAT_FORWARD: begin
				if (fwd_ready) begin
					state_d = RTAT_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_q     <= RTAT_IDLE;
			fwd_addr_q  <= RTAT_ADDR_RESET;
			fwd_index_q <= 3'h0;
			miss_q      <= 1'b0;
			blocked_q   <= 1'b0;
		end else begin
			state_q     <= state_d;
			fwd_addr_q  <= fwd_addr_d;
			fwd_index_q <= fwd_index_d;
			miss_q      <= miss_d;
			blocked_q   <= blocked_d;
		end
	end

	// -------------------------------------------------------------
	// outputs
	// -------------------------------------------------------------
	assign txn_ready   = (state_q == RTAT_IDLE);
	assign fwd_valid   = (state_q == RTAT_FORWARD);
	assign fwd_addr    = fwd_addr_q;
	assign fwd_index   = fwd_index_q;
	assign txn_miss    = miss_q;
	assign txn_blocked = blocked_q;
endmodule : rtat_table
`default_nettype wire

// >>> tb/rtat_monitor.sv
// assertion checker for the remote target address table
`timescale 1ns/1ns
`default_nettype none
module rtat_monitor (
	input wire logic       clock,
	input wire logic       nrst,
	input wire logic       reg_wr_en,
	input wire logic       reg_rd_en,
	input wire logic [7:0] reg_rdata,
	input wire logic       reg_ack,
	input wire logic       txn_valid,
	input wire logic       txn_ready,
	input wire logic       txn_miss,
	input wire logic       txn_blocked,
	input wire logic       fwd_valid,
	input wire logic [6:0] fwd_addr,
	input wire logic [2:0] fwd_index,
	input wire logic       fwd_ready
);
	// ---------------------------------
	// properties
	// ---------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	a_ack_after_strobe: assert property ((reg_wr_en || reg_rd_en) |=> reg_ack)
		else $error("no ack after strobe");
	a_ack_no_cause: assert property (!(reg_wr_en || reg_rd_en) |=> !reg_ack)
		else $error("ack without strobe");
	a_bit0_reads_zero: assert property (!reg_rdata[0])
		else $error("reserved bit read as one");
	a_fwd_holds: assert property (fwd_valid && !fwd_ready |=> fwd_valid && $stable(fwd_addr) && $stable(fwd_index))
		else $error("forward request dropped early");
	a_fwd_legal: assert property (fwd_valid |-> fwd_addr != 7'h00 && fwd_index >= 3'h2 && fwd_index <= 3'h6)
		else $error("bad forward address or index");
	a_busy_refuses: assert property (fwd_valid |-> !txn_ready)
		else $error("ready while forwarding");
	a_fwd_has_cause: assert property ($rose(fwd_valid) |-> $past(txn_valid && txn_ready))
		else $error("forward without request");
	a_txn_answered: assert property (txn_valid && txn_ready |=> $onehot({$rose(fwd_valid), txn_miss, txn_blocked}))
		else $error("request not answered once");
	a_rdata_holds: assert property (!reg_rd_en |=> $stable(reg_rdata))
		else $error("read data changed without a read");
endmodule : rtat_monitor
bind rtat_table rtat_monitor mon (.clock, .nrst, .reg_wr_en, .reg_rd_en, .reg_rdata, .reg_ack, .txn_valid,
	.txn_ready, .txn_miss, .txn_blocked, .fwd_valid, .fwd_addr, .fwd_index, .fwd_ready);
`default_nettype wire

// >>> tb/rtat_fwd_sink.sv
// control channel sink taking forward requests
`timescale 1ns/1ns
`default_nettype none
module rtat_fwd_sink (
	input  wire logic clock,
	input  wire logic slow,
	input  wire logic fwd_valid,
	output var logic  fwd_ready
);
	integer seed = 32'h12A3F441;
	// take at once, or stall at random while slow
	initial begin
		fwd_ready = 1'b0;
		forever begin
			@(posedge clock);
			#1 fwd_ready = fwd_valid && (!slow || $random(seed) % 2 == 0);
		end
	end
endmodule : rtat_fwd_sink
`default_nettype wire

// >>> tb/rtat_table_tb.sv
// self-checking bench for the remote target address table
`timescale 1ns/1ns
`default_nettype none
module rtat_table_tb import rtat_pkg::*;;
	logic clock, nrst, reg_wr_en, reg_rd_en, reg_ack, txn_valid, txn_ready, txn_miss, txn_blocked;
	logic fwd_valid, fwd_ready, slow;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [6:0] txn_addr, fwd_addr;
	logic [2:0] fwd_index;
	logic [4:0][6:0] al, tg;  // alias and model target, index 2 first
	integer seed = 32'h12A3F441;
	integer num_errors = 0;
	integer checks_done = 0;
	int o, r;
	rtat_table uut (.clock, .nrst, .reg_addr, .reg_wr_en, .reg_rd_en, .reg_wdata, .reg_rdata, .reg_ack,
		.alias_addr(al), .txn_valid, .txn_addr, .txn_ready, .txn_miss, .txn_blocked, .fwd_valid,
		.fwd_addr, .fwd_index, .fwd_ready);
	rtat_fwd_sink sink (.clock, .slow, .fwd_valid, .fwd_ready);
	// ---------------------------------
	// tasks
	// ---------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask : check
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish
	// all outputs at their idle values
	task automatic check_idle;
		check(reg_ack, 8'h00);
		check(reg_rdata, 8'h00);
		check(txn_ready, 8'h01);
		check(txn_miss, 8'h00);
		check(txn_blocked, 8'h00);
		check(fwd_valid, 8'h00);
		check(fwd_addr, 8'h00);
		check(fwd_index, 8'h00);
	endtask : check_idle
	task automatic reg_op(input logic wr, input logic [7:0] ofs, input logic [7:0] wd);
		logic hit;
		hit = ofs >= RTAT_OFS_TARGET_2 && ofs <= RTAT_OFS_TARGET_6;
		@(posedge clock);
		#1 {reg_wr_en, reg_rd_en, reg_addr, reg_wdata} = {wr, !wr, ofs, wd};
		@(posedge clock);
		#1 {reg_wr_en, reg_rd_en} = 2'h0;
		check(reg_ack, 8'h01);
		if (wr && hit)
			tg[ofs - RTAT_OFS_TARGET_2] = wd[7:1];
		if (!wr)
			check(reg_rdata, hit ? {tg[ofs - RTAT_OFS_TARGET_2], 1'b0} : 8'h00);
	endtask : reg_op
	task automatic txn(input logic [6:0] a);
		integer k, hit, n;
		hit = -1;
		n = 0;
		for (k = 4; k >= 0; k--)
			if (al[k] != 7'h00 && al[k] == a)
				hit = k;
		@(posedge clock);
		#1 {txn_valid, txn_addr} = {1'b1, a};
		@(posedge clock);
		#1 txn_valid = 1'b0;
		check(txn_miss, hit < 0);
		check(txn_blocked, hit >= 0 && tg[hit] == 7'h00);
		check(fwd_valid, hit >= 0 && tg[hit] != 7'h00);
		check(txn_ready, !(hit >= 0 && tg[hit] != 7'h00));
		if (hit >= 0 && tg[hit] != 7'h00) begin
			check(fwd_addr, tg[hit]);
			check(fwd_index, 8'(hit + 2));
		end
		while (fwd_valid !== 1'b0 && n < 60) begin
			@(posedge clock);
			#1 n++;
		end
		check(fwd_valid, 8'h00);
		check(txn_ready, 8'h01);
	endtask : txn
	// ---------------------------------
	// clock, watchdog and sequence
	// ---------------------------------
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	initial begin
		#400000 num_errors++;
		tally_and_finish;
	end
	initial begin
		{nrst, reg_wr_en, reg_rd_en, reg_addr, reg_wdata, txn_valid, txn_addr, slow} = '0;
		{al, tg} = '0;
		repeat (16) @(posedge clock);
		#1 nrst = 1'b1;
		check_idle;
		for (o = 8'h09; o <= 8'h0F; o++)
			reg_op(1'b0, o, 8'h00);
		for (o = 8'h09; o <= 8'h0F; o++)
			reg_op(1'b1, o, $random(seed) | 8'h02);
		for (o = 8'h09; o <= 8'h0F; o++)
			reg_op(1'b0, o, 8'h00);
		for (o = 0; o < 5; o++)
			al[o] = $random(seed) | 7'h01;
		for (o = 0; o < 5; o++)
			txn(al[o]);
		reg_op(1'b1, RTAT_OFS_TARGET_4, 8'h01);
		txn(al[2]);
		al[3] = al[1];
		txn(al[1]);
		slow = 1'b1;
		for (o = 0; o < 60; o++) begin
			r = $random(seed);
			txn(r[3] ? al[r[6:4] % 5] : r[6:0]);
		end
		@(posedge clock);
		#1 nrst = 1'b0;
		tg = '0;
		repeat (2) @(posedge clock);
		check_idle;
		#1 nrst = 1'b1;
		check_idle;
		for (o = 8'h0A; o <= 8'h0E; o++)
			reg_op(1'b0, o, 8'h00);
		tally_and_finish;
	end
endmodule : rtat_table_tb
`default_nettype wire
